// >>> hdl/io_line_pkg.sv
package io_line_pkg;

  // ==========================================================================
  // Register map: byte addresses of the 32-bit words.
  localparam logic [11:0] OWNER_SET_ADDR      = 12'h000;
  localparam logic [11:0] OWNER_CLEAR_ADDR    = 12'h004;
  localparam logic [11:0] OWNER_STATUS_ADDR   = 12'h008;
  localparam logic [11:0] DRIVER_SET_ADDR     = 12'h010;
  localparam logic [11:0] DRIVER_CLEAR_ADDR   = 12'h014;
  localparam logic [11:0] DRIVER_STATUS_ADDR  = 12'h018;
  localparam logic [11:0] FILTER_SET_ADDR     = 12'h020;
  localparam logic [11:0] FILTER_CLEAR_ADDR   = 12'h024;
  localparam logic [11:0] FILTER_STATUS_ADDR  = 12'h028;
  localparam logic [11:0] VALUE_SET_ADDR      = 12'h030;
  localparam logic [11:0] VALUE_CLEAR_ADDR    = 12'h034;
  localparam logic [11:0] VALUE_STATUS_ADDR   = 12'h038;
  localparam logic [11:0] PIN_LEVEL_ADDR      = 12'h03C;
  localparam logic [11:0] IRQ_ENABLE_SET_ADDR = 12'h040;
  localparam logic [11:0] IRQ_DISABLE_ADDR    = 12'h044;
  localparam logic [11:0] IRQ_MASK_ADDR       = 12'h048;
  localparam logic [11:0] IRQ_STATUS_ADDR     = 12'h04C;
  localparam logic [11:0] WRITE_PERM_SET_ADDR = 12'h0A0;
  localparam logic [11:0] WRITE_PERM_CLR_ADDR = 12'h0A4;
  localparam logic [11:0] WRITE_PERM_STS_ADDR = 12'h0A8;

  // ==========================================================================
  // Implemented lines and reset values.
  localparam logic [31:0] LINES_PRESENT    = 32'hFFFF_FFFF;
  localparam logic [31:0] OWNER_RESET      = 32'hFFFF_FFFF;
  localparam logic [31:0] ZERO_RESET       = 32'h0000_0000;

  // ==========================================================================
  // Glitch filter: a level must stand one cycle longer than this to pass.
  localparam logic [1:0]  FILTER_HOLD_CYCLES = 2'h2;

endpackage

// >>> hdl/io_line_controller.sv
`timescale 1ns/1ns
`default_nettype none
// How it works
// R1: Owner-set ones give lines to the controller.
// R2: Owner-clear ones hand lines to peripherals.
// R3: Owner status reads one for controller lines.
// R4: Driver-set ones enable output drivers.
// R5: Driver-clear ones disable output drivers.
// R6: Driver status shows enabled output drivers.
// R7: Filter-set ones enable glitch filters.
// R8: Filter-clear ones disable glitch filters.
// R9: Filter status shows enabled glitch filters.
// R10: Value-set ones make driven values high.
// R11: Value-clear ones make driven values low.
// R12: Value status reads scheduled drive values.
// R13: Value status readable, writable only on permitted lines.
// R14: Pin level status reads sampled pin levels.
// R15: Direct value writes obey write permission bits.
// R16: Absent lines ignore writes, read zero.
// R17: Irq-enable-set ones enable change interrupts.
// R18: Writes update state on the accepting edge.
module io_line_controller
  import io_line_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  // APB slave.
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Pins.
  input  wire logic [31:0] pin_level_in,
  output logic      [31:0] pin_drive_out,
  output logic      [31:0] pin_drive_en_out,
  // Peripheral side.
  input  wire logic [31:0] periph_drive_in,
  input  wire logic [31:0] periph_drive_en_in,
  output logic      [31:0] periph_level_out,
  // Interrupt.
  output logic             irq_out
);

  // ==========================================================================
  // Bus decode.
  // A transfer is taken in the first access cycle, while pready is still low.
  // The answer follows one edge later, so every write lands on that accepting
  // edge and a read shows the state left by all earlier writes. Holding the
  // access phase one cycle longer cannot take it twice, because pready blocks
  // the second cycle; pready is low again in the third, which is taken anew.
  logic        access;
  logic        wr;
  logic        rd;
  logic        mapped;
  logic [31:0] wdata;
  logic [31:0] owner_reg;
  logic [31:0] driver_reg;
  logic [31:0] filter_reg;
  logic [31:0] value_reg;
  logic [31:0] perm_reg;
  logic [31:0] irq_mask_reg;
  logic [31:0] irq_status_reg;
  logic [31:0] sync1_reg;
  logic [31:0] sync2_reg;
  logic [31:0] level_reg;
  logic [31:0] prev_level_reg;
  logic [1:0]  filt_cnt_reg [32];
  logic [31:0] rdata;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
    return a == b;
  endfunction

  assign access = psel_in && penable_in && !pready_out;
  assign wr     = access && pwrite_in;
  assign rd     = access && !pwrite_in;
  assign wdata  = pwdata_in & LINES_PRESENT;  // [R16]

  // ==========================================================================
  // Pin synchroniser and glitch filter.
  // Pin levels arrive with no relation to the clock. Only the second stage is
  // read by any logic, so a metastable first stage never reaches a decision.
  // The interrupt detector sees the same level as the status register.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_reg <= ZERO_RESET;
      sync2_reg <= ZERO_RESET;
    end else begin
      sync1_reg <= pin_level_in;
      sync2_reg <= sync1_reg;
    end
  end

  // A filtered line takes a new level only after it stood for the hold time.
  // Any return to the old level restarts the count, so short pulses vanish.
  // An unfiltered line follows the synchroniser at once.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      level_reg <= ZERO_RESET;
      for (int i = 0; i < 32; i++) begin
        filt_cnt_reg[i] <= 2'h0;
      end
    end else begin
      for (int i = 0; i < 32; i++) begin
        if (sync2_reg[i] == level_reg[i]) begin
          filt_cnt_reg[i] <= 2'h0;
        end else if (!filter_reg[i] || filt_cnt_reg[i] == FILTER_HOLD_CYCLES) begin
          level_reg[i]    <= sync2_reg[i];
          filt_cnt_reg[i] <= 2'h0;
        end else begin
          filt_cnt_reg[i] <= filt_cnt_reg[i] + 2'h1;
        end
      end
    end
  end

  // ==========================================================================
  // Configuration registers.
  // Each register is a set and clear pair: a one bit acts on its line and a
  // zero bit leaves it alone, so software never needs a read-modify-write.
  logic        owner_set_stb;
  logic        owner_clear_stb;
  logic        driver_set_stb;
  logic        driver_clear_stb;
  logic        filter_set_stb;
  logic        filter_clear_stb;
  logic        value_set_stb;
  logic        value_clear_stb;
  logic        value_direct_stb;
  logic        perm_set_stb;
  logic        perm_clear_stb;
  logic        irq_enable_stb;
  logic        irq_disable_stb;
  logic        status_read_stb;
  logic [31:0] owner_next;
  logic [31:0] driver_next;
  logic [31:0] filter_next;
  logic [31:0] value_next;
  logic [31:0] perm_next;
  logic [31:0] irq_mask_next;

  // Set and clear sit at separate addresses, so they never meet in one write.
  function automatic logic [31:0] set_clear(
    input logic [31:0] cur,
    input logic        set_stb,
    input logic        clr_stb,
    input logic [31:0] bits
  );
    logic [31:0] res;
    res = cur;
    if (set_stb) begin
      res = cur | bits;
    end else if (clr_stb) begin
      res = cur & ~bits;
    end
    return res;
  endfunction

  // Strobes are high only in the accepting cycle of their own address.
  assign owner_set_stb    = wr && hit(paddr_in, OWNER_SET_ADDR);
  assign owner_clear_stb  = wr && hit(paddr_in, OWNER_CLEAR_ADDR);
  assign driver_set_stb   = wr && hit(paddr_in, DRIVER_SET_ADDR);
  assign driver_clear_stb = wr && hit(paddr_in, DRIVER_CLEAR_ADDR);
  assign filter_set_stb   = wr && hit(paddr_in, FILTER_SET_ADDR);
  assign filter_clear_stb = wr && hit(paddr_in, FILTER_CLEAR_ADDR);
  assign value_set_stb    = wr && hit(paddr_in, VALUE_SET_ADDR);
  assign value_clear_stb  = wr && hit(paddr_in, VALUE_CLEAR_ADDR);
  assign value_direct_stb = wr && hit(paddr_in, VALUE_STATUS_ADDR);
  assign perm_set_stb     = wr && hit(paddr_in, WRITE_PERM_SET_ADDR);
  assign perm_clear_stb   = wr && hit(paddr_in, WRITE_PERM_CLR_ADDR);
  assign irq_enable_stb   = wr && hit(paddr_in, IRQ_ENABLE_SET_ADDR);
  assign irq_disable_stb  = wr && hit(paddr_in, IRQ_DISABLE_ADDR);
  assign status_read_stb  = rd && hit(paddr_in, IRQ_STATUS_ADDR);

  // Ownership: a line owned here ignores the peripheral's drive.
  always_comb begin
    owner_next = set_clear(owner_reg, owner_set_stb, owner_clear_stb, wdata);  // [R1] [R2]
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      owner_reg <= OWNER_RESET;
    end else begin
      owner_reg <= owner_next;  // [R18]
    end
  end

  // Output driver enables of owned lines.
  always_comb begin
    driver_next = set_clear(driver_reg, driver_set_stb, driver_clear_stb, wdata);  // [R4] [R5]
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      driver_reg <= ZERO_RESET;
    end else begin
      driver_reg <= driver_next;
    end
  end

  // Glitch filter enables; a change takes effect on the next sample.
  always_comb begin
    filter_next = set_clear(filter_reg, filter_set_stb, filter_clear_stb, wdata);  // [R7] [R8]
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      filter_reg <= ZERO_RESET;
    end else begin
      filter_reg <= filter_next;
    end
  end

  // Drive values; a direct write reaches only the permitted lines.
  always_comb begin
    value_next = set_clear(value_reg, value_set_stb, value_clear_stb, wdata);  // [R10] [R11]
    if (value_direct_stb) begin
      value_next = (value_reg & ~perm_reg) | (wdata & perm_reg);  // [R13] [R15]
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      value_reg <= ZERO_RESET;
    end else begin
      value_reg <= value_next;
    end
  end

  // Direct write permission for the drive values.
  always_comb begin
    perm_next = set_clear(perm_reg, perm_set_stb, perm_clear_stb, wdata);
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      perm_reg <= ZERO_RESET;
    end else begin
      perm_reg <= perm_next;
    end
  end

  // ==========================================================================
  // Input-change interrupt.
  always_comb begin
    irq_mask_next = set_clear(irq_mask_reg, irq_enable_stb, irq_disable_stb, wdata);  // [R17]
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_mask_reg <= ZERO_RESET;
    end else begin
      irq_mask_reg <= irq_mask_next;
    end
  end

  // A change in the read cycle survives the clear, since set wins.
  logic [31:0] change_evt;

  assign change_evt = (level_reg ^ prev_level_reg) & LINES_PRESENT;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_level_reg <= ZERO_RESET;
    end else begin
      prev_level_reg <= level_reg;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_status_reg <= ZERO_RESET;
    end else if (status_read_stb) begin
      irq_status_reg <= change_evt;
    end else begin
      irq_status_reg <= irq_status_reg | change_evt;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // ==========================================================================
  // Pin and peripheral multiplexing.
  // An owned line takes value and enable from the registers; any other line
  // passes the peripheral's own drive through, one cycle late.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_drive_out <= ZERO_RESET;
    end else begin
      pin_drive_out <= ((owner_reg & value_reg) | (~owner_reg & periph_drive_in))
                       & LINES_PRESENT;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_drive_en_out <= ZERO_RESET;
    end else begin
      pin_drive_en_out <= ((owner_reg & driver_reg) | (~owner_reg & periph_drive_en_in))
                          & LINES_PRESENT;
    end
  end

  // Peripherals see the synchronised, filtered level whoever owns the line.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      periph_level_out <= ZERO_RESET;
    end else begin
      periph_level_out <= level_reg;
    end
  end

  // ==========================================================================
  // Read mux and APB answer: one wait state, ready in the second access cycle.
  // Write-only addresses read zero; an unmapped address answers with an error.
  // Status registers ignore writes except the drive values.
  always_comb begin
    mapped = 1'b1;
    rdata  = ZERO_RESET;
    case (paddr_in)
      OWNER_SET_ADDR, OWNER_CLEAR_ADDR, DRIVER_SET_ADDR, DRIVER_CLEAR_ADDR,
      FILTER_SET_ADDR, FILTER_CLEAR_ADDR, VALUE_SET_ADDR, VALUE_CLEAR_ADDR,
      IRQ_ENABLE_SET_ADDR, IRQ_DISABLE_ADDR, WRITE_PERM_SET_ADDR,
      WRITE_PERM_CLR_ADDR: rdata = ZERO_RESET;
      OWNER_STATUS_ADDR:   rdata = owner_reg;  // [R3]
      DRIVER_STATUS_ADDR:  rdata = driver_reg;  // [R6]
      FILTER_STATUS_ADDR:  rdata = filter_reg;  // [R9]
      VALUE_STATUS_ADDR:   rdata = value_reg;  // [R12]
      PIN_LEVEL_ADDR:      rdata = level_reg;  // [R14]
      IRQ_MASK_ADDR:       rdata = irq_mask_reg;
      IRQ_STATUS_ADDR:     rdata = irq_status_reg;
      WRITE_PERM_STS_ADDR: rdata = perm_reg;
      default:             mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else if (access) begin
      pready_out  <= 1'b1;
      pslverr_out <= !mapped;
    end else begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end
  end

  // Read data stands only with pready, so a stale word never stays on the bus.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_out <= ZERO_RESET;
    end else if (rd) begin
      prdata_out <= rdata & LINES_PRESENT;  // [R16]
    end else begin
      prdata_out <= ZERO_RESET;
    end
  end

endmodule
`default_nettype wire

// >>> testbench/io_line_checker.sv
`timescale 1ns/1ns
`default_nettype none
module io_line_checker
  import io_line_pkg::*;
(
  // Clock, reset and bus.
  input wire logic        clk_sys_in,
  input wire logic        rst_n_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  // Interrupt.
  input wire logic        irq_out
);
  logic      [31:0] own_m;
  wire logic        wr_acc = psel_in & penable_in & pwrite_in & ~pready_out;
  // =========================================================================
  // Ownership mirror.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      own_m <= OWNER_RESET;
    end else if (wr_acc && paddr_in == OWNER_SET_ADDR) begin
      own_m <= own_m | pwdata_in;
    end else if (wr_acc && paddr_in == OWNER_CLEAR_ADDR) begin
      own_m <= own_m & ~pwdata_in;
    end
  end
  // =========================================================================
  // Properties.
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  sequence acc_wait;
    psel_in && penable_in && !pready_out;
  endsequence
  sequence rd_done(a);
    pready_out && !pwrite_in && paddr_in == a;
  endsequence
  ready_wait_a: assert property (acc_wait |=> pready_out)
    else $error("ready late");
  ready_pulse_a: assert property (pready_out |=> !pready_out)
    else $error("ready too long");
  ready_cause_a: assert property (pready_out |-> $past(psel_in && penable_in))
    else $error("ready without access");
  owner_read_a: assert property (rd_done(OWNER_STATUS_ADDR) |-> prdata_out == own_m)
    else $error("owner status wrong");
  reserved_err_a: assert property (pready_out && paddr_in == 12'h00C |-> pslverr_out)
    else $error("reserved not refused");
  wo_zero_a: assert property (rd_done(DRIVER_SET_ADDR) |-> prdata_out == 32'h0000_0000)
    else $error("write-only read not zero");
  pin_ok_a: assert property (rd_done(PIN_LEVEL_ADDR) |-> !pslverr_out)
    else $error("pin level refused");
  irq_off_a: assert property (acc_wait ##0 (pwrite_in && paddr_in == IRQ_DISABLE_ADDR
    && pwdata_in == 32'hFFFF_FFFF) |-> ##2 !irq_out)
    else $error("irq after disable");
endmodule
bind io_line_controller io_line_checker chk_u (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .irq_out(irq_out));
`default_nettype wire

// >>> testbench/pin_world.sv
`timescale 1ns/1ns
`default_nettype none
module pin_world (
  // Pad side.
  input  wire logic [31:0] drive_in,
  input  wire logic [31:0] drive_en_in,
  input  wire logic [31:0] ext_level_in,
  output logic      [31:0] level_out
);
  // An undriven pad follows whatever the outside world applies.
  assign level_out = (drive_en_in & drive_in) | (~drive_en_in & ext_level_in);
endmodule
`default_nettype wire

// >>> testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import io_line_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [11:0] padr = 12'h000;
  logic [31:0] pwd = 32'h0000_0000;
  logic [31:0] ext = 32'h0000_0000;
  logic [31:0] p_dv = 32'h0000_0000;
  logic [31:0] p_en = 32'h0000_0000;
  logic [31:0] prd, dv, en, lvl, rdat, plv;
  logic        rdy, serr, irq, rerr;
  int          err_count = 0;
  int          cmp_count = 0;
  always #10 clk_sys_in = ~clk_sys_in;
  io_line_controller dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(padr), .pwdata_in(pwd), .prdata_out(prd),
    .pready_out(rdy), .pslverr_out(serr), .pin_level_in(lvl), .pin_drive_out(dv),
    .pin_drive_en_out(en), .periph_drive_in(p_dv), .periph_drive_en_in(p_en),
    .periph_level_out(plv), .irq_out(irq));
  pin_world pads (.drive_in(dv), .drive_en_in(en), .ext_level_in(ext), .level_out(lvl));
  task summarize;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk_sys_in);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (rdy !== 1'b1 && n < 20);
    if (rdy !== 1'b1) begin
      err_count++;
      summarize();
    end
    rdat = prd;
    rerr = serr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task rd(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rdat);
  endtask
  task t_reset;
    rd("owner", OWNER_STATUS_ADDR, 32'hFFFF_FFFF);
    rd("driver", DRIVER_STATUS_ADDR, 32'h0000_0000);
    rd("filter", FILTER_STATUS_ADDR, 32'h0000_0000);
    rd("value", VALUE_STATUS_ADDR, 32'h0000_0000);
    $display("t_reset done");
  endtask
  task t_owner;
    p_en <= 32'h0000_F000;
    p_dv <= 32'h0000_A000;
    apb(1'b1, OWNER_CLEAR_ADDR, 32'h0000_FF00);
    rd("owner clr", OWNER_STATUS_ADDR, 32'hFFFF_00FF);
    apb(1'b1, OWNER_SET_ADDR, 32'h0000_0F00);
    rd("owner set", OWNER_STATUS_ADDR, 32'hFFFF_0FFF);
    chk("periph en", 32'h0000_F000, en & 32'h0000_FF00);
    chk("periph dv", 32'h0000_A000, dv & 32'h0000_F000);
    $display("t_owner done");
  endtask
  task t_drive;
    apb(1'b1, DRIVER_SET_ADDR, 32'h0000_00FF);
    apb(1'b1, DRIVER_CLEAR_ADDR, 32'h0000_000F);
    rd("drv sts", DRIVER_STATUS_ADDR, 32'h0000_00F0);
    apb(1'b1, VALUE_SET_ADDR, 32'h0000_00A0);
    apb(1'b1, VALUE_CLEAR_ADDR, 32'h0000_0020);
    rd("val sts", VALUE_STATUS_ADDR, 32'h0000_0080);
    apb(1'b1, WRITE_PERM_SET_ADDR, 32'h0000_0010);
    apb(1'b1, VALUE_STATUS_ADDR, 32'hFFFF_FFFF);
    rd("val direct", VALUE_STATUS_ADDR, 32'h0000_0090);
    rd("perm sts", WRITE_PERM_STS_ADDR, 32'h0000_0010);
    apb(1'b1, WRITE_PERM_CLR_ADDR, 32'h0000_0010);
    apb(1'b1, VALUE_STATUS_ADDR, 32'h0000_0000);
    rd("val locked", VALUE_STATUS_ADDR, 32'h0000_0090);
    chk("pin en", 32'h0000_F0F0, en & 32'h0000_FFFF);
    chk("pin dv", 32'h0000_A090, dv & 32'h0000_F0F0);
    $display("t_drive done");
  endtask
  task t_filter;
    apb(1'b1, FILTER_SET_ADDR, 32'h0000_0300);
    apb(1'b1, FILTER_CLEAR_ADDR, 32'h0000_0100);
    rd("flt sts", FILTER_STATUS_ADDR, 32'h0000_0200);
    ext <= 32'h5A5A_5A5A;
    repeat (8) @(posedge clk_sys_in);
    rd("pins", PIN_LEVEL_ADDR, 32'h5A5A_AA9A);
    chk("periph lvl", 32'h5A5A_AA9A, plv);
    $display("t_filter done");
  endtask
  task t_irq;
    int n;
    apb(1'b0, IRQ_STATUS_ADDR, 32'h0000_0000);
    apb(1'b1, IRQ_ENABLE_SET_ADDR, 32'h0001_0000);
    rd("mask", IRQ_MASK_ADDR, 32'h0001_0000);
    ext <= ext ^ 32'h0003_0000;
    for (n = 0; n < 20 && irq !== 1'b1; n++) begin
      @(posedge clk_sys_in);
    end
    chk("irq", 32'h0000_0001, {31'h0, irq});
    rd("irq sts", IRQ_STATUS_ADDR, 32'h0003_0000);
    chk("irq clr", 32'h0000_0000, {31'h0, irq});
    rd("sts clr", IRQ_STATUS_ADDR, 32'h0000_0000);
    apb(1'b1, IRQ_DISABLE_ADDR, 32'hFFFF_FFFF);
    rd("mask off", IRQ_MASK_ADDR, 32'h0000_0000);
    $display("t_irq done");
  endtask
  task t_bad;
    rd("reserved", 12'h00C, 32'h0000_0000);
    chk("slverr", 32'h0000_0001, {31'h0, rerr});
    rd("wo read", DRIVER_SET_ADDR, 32'h0000_0000);
    $display("t_bad done");
  endtask
  initial begin
    repeat (4) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    t_reset();
    t_owner();
    t_drive();
    t_filter();
    t_irq();
    t_bad();
    summarize();
  end
endmodule
`default_nettype wire
